// ===== rtl/csrs_pkg.sv
// Purpose: Shared constants and types for the system register set.
// Assumes: One core clock; register numbers are fixed encodings.
// Notes: Every width, mask, number and reset value is named here.
package csrs_pkg;

  // Data path width of every register.
  localparam int unsigned XLEN = 32;
  // Number of implemented status word flag bits.
  localparam int unsigned STATUS_W = 8;
  // Width of a general register index and of a system register number.
  localparam int unsigned IDX_W = 5;

  // Program address mask: bits 31 to 26 and bit 0 are forced low.
  localparam logic [31:0] PC_MASK = 32'h03FF_FFFE;
  // Base pointer mask, identical in shape to the program address mask.
  localparam logic [31:0] BASE_MASK = 32'h03FF_FFFE;
  // Save registers keep bits 25 to 0 as written; bit 0 is dropped on return.
  localparam logic [31:0] SAVE_PC_MASK = 32'h03FF_FFFF;

  // Reset values.
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // System register numbers.
  localparam logic [4:0] SR_MSK_PC = 5'h00;
  localparam logic [4:0] SR_MSK_ST = 5'h01;
  localparam logic [4:0] SR_NMI_PC = 5'h02;
  localparam logic [4:0] SR_NMI_ST = 5'h03;
  localparam logic [4:0] SR_SRC = 5'h04;
  localparam logic [4:0] SR_STATUS = 5'h05;
  localparam logic [4:0] SR_CALL_PC = 5'h06;
  localparam logic [4:0] SR_CALL_ST = 5'h07;
  localparam logic [4:0] SR_TRAP_PC = 5'h08;
  localparam logic [4:0] SR_TRAP_ST = 5'h09;
  localparam logic [4:0] SR_CALL_BASE = 5'h0A;

  // Kinds of accepted events that save a register pair.
  typedef enum logic [2:0] {
    CSRS_EV_NONE = 3'b000,
    CSRS_EV_MASK = 3'b001,
    CSRS_EV_NMI = 3'b010,
    CSRS_EV_CALL = 3'b011,
    CSRS_EV_TRAP = 3'b100
  } csrs_event_t;

endpackage : csrs_pkg

// ===== rtl/csrs_core_regs.sv
// Purpose: Program counter, general registers and system register set.
// Assumes: The pipeline presents at most one accepted event per cycle.
// Notes: Events win over returns, returns over loads, loads over updates.
//
// Overview of operation
// RL1 - Register zero always reads as zero.
// RL2 - Program counter keeps 26 bits, upper zero.
// RL3 - Program counter bit 0 always zero.
// RL4 - System register number selects target register.
// RL5 - Maskable or software exception saves counter, status.
// RL6 - Saved return address is following instruction.
// RL7 - Non-maskable interrupt saves counter and status.
// RL8 - Interrupt return restores from maskable pair.
// RL9 - Interrupt return after NMI restores NMI pair.
// RL10 - Save registers hold reserved bits at zero.
// RL11 - Saved counter bit 0 ignored on return.
// RL12 - Events other than table calls record code; loads cannot write it.
// RL13 - Loaded status word valid for next instruction.
// RL14 - Interrupt acknowledge deferred during status load.
// RL15 - Status word upper bits read zero.
// RL16 - Table call saves following address and status.
// RL17 - Exception or debug trap saves counter, status.
// RL18 - Trap pair accessible only inside trap window.
// RL19 - Trap return restores from trap pair.
// RL20 - Table base bit 0 and upper bits zero.
// RL21 - Pair saved in the accepting cycle.
`timescale 1ns/100ps
`default_nettype none

module csrs_core_regs (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Accepted event from the pipeline.
  input wire csrs_pkg::csrs_event_t evt_kind,
  input wire logic [31:0] evt_code,
  input wire logic [31:0] evt_next_pc,
  input wire logic [31:0] evt_target_pc,
  // Return instructions.
  input wire logic ret_req,
  input wire logic ret_from_nmi,
  input wire logic trap_ret_req,
  // Ordinary program counter update.
  input wire logic pc_wr,
  input wire logic [31:0] pc_wdata,
  // Flag update from execution.
  input wire logic flags_wr,
  input wire logic [7:0] flags_wdata,
  // System register load and store.
  input wire logic sr_load,
  input wire logic sr_store,
  input wire logic [4:0] sr_num,
  input wire logic [31:0] sr_wdata,
  output logic [31:0] sr_rdata,
  output logic sr_refused,
  // General registers.
  input wire logic gpr_wr,
  input wire logic [4:0] gpr_waddr,
  input wire logic [31:0] gpr_wdata,
  input wire logic [4:0] gpr_raddr,
  output logic [31:0] gpr_rdata,
  // Core state.
  output logic [31:0] pc,
  output logic [31:0] status_word,
  output logic [31:0] table_base,
  output logic trap_window,
  output logic irq_hold
);
  import csrs_pkg::*;

  // Architectural state.
  logic [31:0] pc_q;
  logic [7:0] stat_q;
  logic [31:0] msk_pc_q;
  logic [7:0] msk_st_q;
  logic [31:0] nmi_pc_q;
  logic [7:0] nmi_st_q;
  logic [31:0] src_q;
  logic [31:0] call_pc_q;
  logic [7:0] call_st_q;
  logic [31:0] trap_pc_q;
  logic [7:0] trap_st_q;
  logic [31:0] base_q;
  logic trap_win_q;
  logic [31:0] sr_rdata_q;
  logic refused_q;
  logic [31:0] gpr_rdata_q;
  // General register storage; entry zero is never read.
  logic [31:0] gpr_mem [0:31];

  // Decoded requests.
  logic ev_any;
  logic trap_reg_sel;
  logic access_ok;
  logic ld_ok;
  logic st_ok;

  // Any event that saves a pair this cycle.
  assign ev_any = (evt_kind != CSRS_EV_NONE);
  // The trap pair needs the trap window for either direction.
  assign trap_reg_sel = (sr_num == SR_TRAP_PC) || (sr_num == SR_TRAP_ST);
  assign access_ok = !trap_reg_sel || trap_win_q; // RL18
  // A load loses to an event or a return in the same cycle.
  assign ld_ok = sr_load && access_ok && !ev_any && !ret_req && !trap_ret_req;
  assign st_ok = sr_store && access_ok;

  // Interrupt acknowledge is held off while the status word is loaded.
  assign irq_hold = sr_load && (sr_num == SR_STATUS); // RL14

  // Program counter: event target, restores, then branch writes.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pc_q <= PC_RST;
    end else if (ev_any) begin
      pc_q <= evt_target_pc & PC_MASK; // RL2 RL3
    end else if (trap_ret_req) begin
      pc_q <= trap_pc_q & PC_MASK; // RL19 RL11
    end else if (ret_req && ret_from_nmi) begin
      pc_q <= nmi_pc_q & PC_MASK; // RL9 RL11
    end else if (ret_req) begin
      pc_q <= msk_pc_q & PC_MASK; // RL8 RL11
    end else if (pc_wr) begin
      pc_q <= pc_wdata & PC_MASK; // RL2 RL3
    end
  end

  // Status word: restores, then loads, then flag updates.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stat_q <= STATUS_RST;
    end else if (ev_any) begin
      stat_q <= stat_q;
    end else if (trap_ret_req) begin
      stat_q <= trap_st_q; // RL19
    end else if (ret_req && ret_from_nmi) begin
      stat_q <= nmi_st_q; // RL9
    end else if (ret_req) begin
      stat_q <= msk_st_q; // RL8
    end else if (ld_ok && sr_num == SR_STATUS) begin
      stat_q <= sr_wdata[7:0]; // RL13
    end else if (flags_wr) begin
      stat_q <= flags_wdata;
    end
  end

  // Maskable pair: saved on maskable interrupts and software exceptions.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      msk_pc_q <= REG_RST;
      msk_st_q <= STATUS_RST;
    end else if (evt_kind == CSRS_EV_MASK) begin
      msk_pc_q <= evt_next_pc & SAVE_PC_MASK; // RL5 RL6 RL21
      msk_st_q <= stat_q; // RL5 RL21
    end else if (ld_ok && sr_num == SR_MSK_PC) begin
      msk_pc_q <= sr_wdata & SAVE_PC_MASK; // RL4 RL10
    end else if (ld_ok && sr_num == SR_MSK_ST) begin
      msk_st_q <= sr_wdata[7:0]; // RL4 RL10
    end
  end

  // NMI pair.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nmi_pc_q <= REG_RST;
      nmi_st_q <= STATUS_RST;
    end else if (evt_kind == CSRS_EV_NMI) begin
      nmi_pc_q <= evt_next_pc & SAVE_PC_MASK; // RL7 RL21
      nmi_st_q <= stat_q; // RL7 RL21
    end else if (ld_ok && sr_num == SR_NMI_PC) begin
      nmi_pc_q <= sr_wdata & SAVE_PC_MASK; // RL10
    end else if (ld_ok && sr_num == SR_NMI_ST) begin
      nmi_st_q <= sr_wdata[7:0]; // RL10
    end
  end

  // Table call pair.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      call_pc_q <= REG_RST;
      call_st_q <= STATUS_RST;
    end else if (evt_kind == CSRS_EV_CALL) begin
      call_pc_q <= evt_next_pc & SAVE_PC_MASK; // RL16 RL21
      call_st_q <= stat_q; // RL16 RL21
    end else if (ld_ok && sr_num == SR_CALL_PC) begin
      call_pc_q <= sr_wdata & SAVE_PC_MASK; // RL10
    end else if (ld_ok && sr_num == SR_CALL_ST) begin
      call_st_q <= sr_wdata[7:0]; // RL10
    end
  end

  // Trap pair.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trap_pc_q <= REG_RST;
      trap_st_q <= STATUS_RST;
    end else if (evt_kind == CSRS_EV_TRAP) begin
      trap_pc_q <= evt_next_pc & SAVE_PC_MASK; // RL17 RL21
      trap_st_q <= stat_q; // RL17 RL21
    end else if (ld_ok && sr_num == SR_TRAP_PC) begin
      trap_pc_q <= sr_wdata & SAVE_PC_MASK; // RL18
    end else if (ld_ok && sr_num == SR_TRAP_ST) begin
      trap_st_q <= sr_wdata[7:0]; // RL18
    end
  end

  // Trap window opens on a trap and closes on the trap return.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      trap_win_q <= 1'b0;
    end else if (evt_kind == CSRS_EV_TRAP) begin
      trap_win_q <= 1'b1; // RL18
    end else if (trap_ret_req) begin
      trap_win_q <= 1'b0; // RL18
    end
  end

  // Exception source code: written only by events, never by loads.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_q <= REG_RST;
    end else if (ev_any && evt_kind != CSRS_EV_CALL) begin
      src_q <= evt_code; // RL12
    end
  end

  // Table base pointer.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      base_q <= REG_RST;
    end else if (ld_ok && sr_num == SR_CALL_BASE) begin
      base_q <= sr_wdata & BASE_MASK; // RL20
    end
  end

  // Store read-back, registered; refused or unmapped reads give zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sr_rdata_q <= REG_RST;
    end else if (st_ok) begin
      case (sr_num) // RL4
        SR_MSK_PC: sr_rdata_q <= msk_pc_q;
        SR_MSK_ST: sr_rdata_q <= {24'h000000, msk_st_q}; // RL10
        SR_NMI_PC: sr_rdata_q <= nmi_pc_q;
        SR_NMI_ST: sr_rdata_q <= {24'h000000, nmi_st_q};
        SR_SRC: sr_rdata_q <= src_q;
        SR_STATUS: sr_rdata_q <= {24'h000000, stat_q}; // RL15
        SR_CALL_PC: sr_rdata_q <= call_pc_q;
        SR_CALL_ST: sr_rdata_q <= {24'h000000, call_st_q};
        SR_TRAP_PC: sr_rdata_q <= trap_pc_q;
        SR_TRAP_ST: sr_rdata_q <= {24'h000000, trap_st_q};
        SR_CALL_BASE: sr_rdata_q <= base_q;
        default: sr_rdata_q <= REG_RST;
      endcase
    end else if (sr_store) begin
      sr_rdata_q <= REG_RST; // RL18
    end
  end

  // Refusal flag: one-cycle pulse after a refused trap pair access.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= (sr_load || sr_store) && !access_ok; // RL18
    end
  end

  // General register write; writes to entry zero are dropped.
  always_ff @(posedge ref_clk) begin
    if (gpr_wr && gpr_waddr != 5'h00) begin
      gpr_mem[gpr_waddr] <= gpr_wdata;
    end
  end

  // General register read, registered; entry zero reads as zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gpr_rdata_q <= REG_RST;
    end else if (gpr_raddr == 5'h00) begin
      gpr_rdata_q <= REG_RST; // RL1
    end else begin
      gpr_rdata_q <= gpr_mem[gpr_raddr];
    end
  end

  // Outputs.
  assign pc = pc_q;
  assign status_word = {24'h000000, stat_q}; // RL15
  assign table_base = base_q;
  assign trap_window = trap_win_q;
  assign sr_rdata = sr_rdata_q;
  assign sr_refused = refused_q;
  assign gpr_rdata = gpr_rdata_q;

  // Checks on the visible behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_zero_reg_read: assert property ( // RL1
    gpr_raddr == 5'h00 |=> gpr_rdata == 32'h0000_0000)
    else $error("Register zero read back nonzero.");

  chk_pc_bits_fixed: assert property ( // RL2
    pc[31:26] == 6'h00 && pc[0] == 1'b0 && table_base[31:26] == 6'h00 && table_base[0] == 1'b0)
    else $error("Fixed address bits are not zero.");

  chk_mask_pair_save: assert property ( // RL5
    evt_kind == CSRS_EV_MASK |=> msk_pc_q == ($past(evt_next_pc) & SAVE_PC_MASK)
      && msk_st_q == $past(stat_q))
    else $error("Maskable pair not saved on event.");

  chk_nmi_pair_save: assert property ( // RL7
    evt_kind == CSRS_EV_NMI |=> nmi_pc_q == ($past(evt_next_pc) & SAVE_PC_MASK)
      && nmi_st_q == $past(stat_q))
    else $error("NMI pair not saved on event.");

  chk_ret_restore: assert property ( // RL8
    !ev_any && !trap_ret_req && ret_req && !ret_from_nmi
      |=> pc == ($past(msk_pc_q) & PC_MASK) && status_word[7:0] == $past(msk_st_q))
    else $error("Return did not restore maskable pair.");

  chk_nmi_ret_restore: assert property ( // RL9
    !ev_any && !trap_ret_req && ret_req && ret_from_nmi
      |=> pc == ($past(nmi_pc_q) & PC_MASK) && status_word[7:0] == $past(nmi_st_q))
    else $error("Return did not restore NMI pair.");

  chk_source_readonly: assert property ( // RL12
    !ev_any || evt_kind == CSRS_EV_CALL |=> $stable(src_q))
    else $error("Source code changed without an event.");

  chk_status_load_next: assert property ( // RL13
    ld_ok && sr_num == SR_STATUS |=> status_word == {24'h000000, $past(sr_wdata[7:0])})
    else $error("Loaded status word not visible next cycle.");

  chk_irq_hold_load: assert property ( // RL14
    sr_load && sr_num == SR_STATUS |-> irq_hold)
    else $error("Acknowledge not held during status load.");

  chk_call_pair_save: assert property ( // RL16
    evt_kind == CSRS_EV_CALL |=> call_pc_q == ($past(evt_next_pc) & SAVE_PC_MASK)
      && call_st_q == $past(stat_q))
    else $error("Table call pair not saved.");

  chk_trap_refused: assert property ( // RL18
    (sr_load || sr_store) && trap_reg_sel && !trap_win_q && evt_kind != CSRS_EV_TRAP
      |=> sr_refused && $stable(trap_pc_q) && $stable(trap_st_q)
      && (!$past(sr_store) || sr_rdata == 32'h0000_0000))
    else $error("Trap pair access outside window not refused.");

  chk_trap_ret_restore: assert property ( // RL19
    !ev_any && trap_ret_req |=> pc == ($past(trap_pc_q) & PC_MASK)
      && status_word[7:0] == $past(trap_st_q) && !trap_window)
    else $error("Trap return did not restore trap pair.");

endmodule : csrs_core_regs

`default_nettype wire

// ===== sim/csrs_core_regs_tb_top.sv
// Purpose: Self-checking bench for the system register set.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes: Plain register accesses sit in a table; events are hand-written.
`timescale 1ns/100ps
`default_nettype none

module csrs_core_regs_tb_top;
  import csrs_pkg::*;

  // One table row: register number, value written, value read back, refusal.
  typedef struct packed {logic [4:0] num; logic [31:0] wr; logic [31:0] exp; logic ref_e;} csrs_tb_row_t;

  // Stimulus, all given a value at time zero.
  logic ref_clk = 1'b0, rst_n = 1'b0;
  csrs_event_t evt_kind = CSRS_EV_NONE;
  logic [31:0] evt_code = 32'h0, evt_next_pc = 32'h0, evt_target_pc = 32'h0;
  logic ret_req = 1'b0, ret_from_nmi = 1'b0, trap_ret_req = 1'b0, pc_wr = 1'b0, flags_wr = 1'b0;
  logic [31:0] pc_wdata = 32'h0, sr_wdata = 32'h0, gpr_wdata = 32'h0;
  logic [7:0] flags_wdata = 8'h00;
  logic sr_load = 1'b0, sr_store = 1'b0, gpr_wr = 1'b0;
  logic [4:0] sr_num = 5'h00, gpr_waddr = 5'h00, gpr_raddr = 5'h00;
  // Observed outputs.
  logic [31:0] sr_rdata, gpr_rdata, pc, status_word, table_base;
  logic sr_refused, trap_window, irq_hold;
  // Bookkeeping.
  int bad_count = 0, n_checks = 0, cycles = 0;
  logic [31:0] rd_val, last_code = 32'h0;
  logic rd_ref;
  csrs_tb_row_t rows [12] = '{
    '{SR_MSK_PC, 32'hFFFF_FFFF, 32'h03FF_FFFF, 1'b0}, '{SR_MSK_ST, 32'hFFFF_FFFF, 32'h0000_00FF, 1'b0},
    '{SR_NMI_PC, 32'hFFFF_FFFF, 32'h03FF_FFFF, 1'b0}, '{SR_NMI_ST, 32'hFFFF_FFFF, 32'h0000_00FF, 1'b0},
    '{SR_SRC, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0}, '{SR_STATUS, 32'hFFFF_FF3C, 32'h0000_003C, 1'b0},
    '{SR_CALL_PC, 32'hFFFF_FFFF, 32'h03FF_FFFF, 1'b0}, '{SR_CALL_ST, 32'hFFFF_FFFF, 32'h0000_00FF, 1'b0},
    '{SR_TRAP_PC, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}, '{SR_TRAP_ST, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
    '{SR_CALL_BASE, 32'hFFFF_FFFF, 32'h03FF_FFFE, 1'b0}, '{5'h1F, 32'h1234_5678, 32'h0000_0000, 1'b0}};

  // Design under test.
  csrs_core_regs dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .evt_kind(evt_kind), .evt_code(evt_code),
    .evt_next_pc(evt_next_pc), .evt_target_pc(evt_target_pc), .ret_req(ret_req),
    .ret_from_nmi(ret_from_nmi), .trap_ret_req(trap_ret_req), .pc_wr(pc_wr), .pc_wdata(pc_wdata),
    .flags_wr(flags_wr), .flags_wdata(flags_wdata), .sr_load(sr_load), .sr_store(sr_store),
    .sr_num(sr_num), .sr_wdata(sr_wdata), .sr_rdata(sr_rdata), .sr_refused(sr_refused),
    .gpr_wr(gpr_wr), .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata), .gpr_raddr(gpr_raddr),
    .gpr_rdata(gpr_rdata), .pc(pc), .status_word(status_word), .table_base(table_base),
    .trap_window(trap_window), .irq_hold(irq_hold));

  // Clock of 25 ns period.
  always #12.5 ref_clk = ~ref_clk;

  // A hang is cut short at cycle 3000, well beyond the roughly 130 cycles the run needs.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end

  // Prints the verdict and ends the run.
  task test_done();
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // Compares a word.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk32

  // Compares a flag.
  task automatic chk1(input logic got, input logic exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // System register load; the interrupt hold shows in the load cycle.
  task automatic sr_wr(input logic [4:0] num, input logic [31:0] data);
    @(posedge ref_clk);
    sr_load <= 1'b1;
    sr_num <= num;
    sr_wdata <= data;
    #1;
    chk1(irq_hold, num == SR_STATUS);
    @(posedge ref_clk);
    sr_load <= 1'b0;
    #1;
  endtask : sr_wr

  // System register store; data and refusal arrive one edge later.
  task automatic rd_chk(input logic [4:0] num, input logic [31:0] exp);
    @(posedge ref_clk);
    sr_store <= 1'b1;
    sr_num <= num;
    @(posedge ref_clk);
    sr_store <= 1'b0;
    #1;
    rd_ref = sr_refused;
    chk32(sr_rdata, exp);
  endtask : rd_chk

  // One-cycle pulse on an event or a return.
  task automatic fire(input csrs_event_t k, input logic [31:0] code, input logic [31:0] nxt, input logic [2:0] rt);
    @(posedge ref_clk);
    evt_kind <= k;
    evt_code <= code;
    evt_next_pc <= nxt;
    evt_target_pc <= 32'hFFFF_F103;
    ret_req <= rt[0];
    ret_from_nmi <= rt[1];
    trap_ret_req <= rt[2];
    @(posedge ref_clk);
    evt_kind <= CSRS_EV_NONE;
    ret_req <= 1'b0;
    ret_from_nmi <= 1'b0;
    trap_ret_req <= 1'b0;
    #1;
  endtask : fire

  // Takes one event kind, checks its saved pair, then returns from it unless it is a table call.
  task automatic ev_case(input csrs_event_t k, input logic [4:0] pcn);
    logic [31:0] nxt;
    logic [7:0] ps;
    nxt = 32'hFC00_0101 | {25'h0, k, 4'h0};
    ps = 8'h50 | {5'h0, k};
    sr_wr(SR_STATUS, {24'hFF_FFFF, ps});
    chk32(status_word, {24'h0, ps});
    fire(k, 32'h0000_0100 | {29'h0, k}, nxt, 3'b000);
    chk32(pc, 32'h03FF_F102);
    chk32(status_word, {24'h0, ps});
    chk1(trap_window, k == CSRS_EV_TRAP);
    rd_chk(pcn, nxt & SAVE_PC_MASK);
    rd_chk(pcn + 5'h01, {24'h0, ps});
    if (k != CSRS_EV_CALL) begin
      last_code = 32'h0000_0100 | {29'h0, k};
    end
    rd_chk(SR_SRC, last_code);
    @(posedge ref_clk);
    flags_wr <= 1'b1;
    flags_wdata <= 8'h0F;
    @(posedge ref_clk);
    flags_wr <= 1'b0;
    #1;
    chk32(status_word, 32'h0000_000F);
    if (k == CSRS_EV_TRAP) begin
      // An odd return address loses bit 0 on the way back.
      nxt = 32'h0000_0777;
      sr_wr(SR_TRAP_PC, nxt);
      rd_chk(SR_TRAP_PC, nxt);
      chk1(rd_ref, 1'b0);
    end
    if (k != CSRS_EV_CALL) begin
      fire(CSRS_EV_NONE, 32'h0, 32'h0, {k == CSRS_EV_TRAP, k == CSRS_EV_NMI, k != CSRS_EV_TRAP});
      chk32(pc, nxt & PC_MASK);
      chk32(status_word, {24'h0, ps});
    end
  endtask : ev_case

  // Main sequence.
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk32(pc, 32'h0);
    chk32(status_word, 32'h0);
    chk32(table_base, 32'h0);
    chk1(trap_window, 1'b0);
    chk1(sr_refused, 1'b0);
    // Table of plain loads and stores.
    foreach (rows[i]) begin
      sr_wr(rows[i].num, rows[i].wr);
      rd_chk(rows[i].num, rows[i].exp);
      if (rows[i].num <= SR_CALL_BASE) begin
        chk1(rd_ref, rows[i].ref_e);
      end
    end
    chk32(table_base, 32'h03FF_FFFE);
    // Register zero drops writes; another register keeps them.
    for (int r = 0; r < 6; r = r + 5) begin
      @(posedge ref_clk);
      gpr_wr <= 1'b1;
      gpr_waddr <= r[4:0];
      gpr_wdata <= 32'hDEAD_BEEF;
      @(posedge ref_clk);
      gpr_wr <= 1'b0;
      gpr_raddr <= r[4:0];
      @(posedge ref_clk);
      #1;
      chk32(gpr_rdata, (r == 0) ? 32'h0 : 32'hDEAD_BEEF);
    end
    // Carry past bit 25 and an odd target are both dropped.
    @(posedge ref_clk);
    pc_wr <= 1'b1;
    pc_wdata <= 32'hFFFF_FFFF;
    @(posedge ref_clk);
    pc_wr <= 1'b0;
    #1;
    chk32(pc, 32'h03FF_FFFE);
    ev_case(CSRS_EV_MASK, SR_MSK_PC);
    ev_case(CSRS_EV_NMI, SR_NMI_PC);
    ev_case(CSRS_EV_CALL, SR_CALL_PC);
    ev_case(CSRS_EV_TRAP, SR_TRAP_PC);
    // After the trap return the trap pair is shut again.
    chk1(trap_window, 1'b0);
    rd_chk(SR_TRAP_ST, 32'h0);
    chk1(rd_ref, 1'b1);
    // A second reset in mid-run clears the state once more.
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk32(pc, 32'h0);
    rd_chk(SR_MSK_PC, 32'h0);
    test_done();
  end

endmodule : csrs_core_regs_tb_top

`default_nettype wire
